/* File: shared/ppfs_regs.svh */
// Notes on behaviour
// - Port 1 bit 7 input pulls up only while its pull-up enable is 1.
// - Port 3 bits 1 and 3 share one pull-up, enabled by its bit.
// - Port 3 bit 4 input pulls up only while its enable is 1.
// - Serial select goes to port 3 bit 3 only when its selector is 0.
// - Interrupt 1 comes from port 1 bit 7 when selector 0 and enabled.
// - Port 3 bit 1 carries timer B output: selector 0, control 0, mode nonzero.
// - Timer B control 1 in waveform mode makes port 3 bit 1 a plain port pin, set by its direction bit.
// - Timer B output drives port 3 bit 1 regardless of direction bit.
// - Port 3 bit 3 is open drain when serial open-drain 1, bidirectional 0.
// - Port 3 bit 4 as chip-select output is open drain when its bit is 1.
// - Port 3 bit 4 outputs channel C PWM with selector, enables and PWM set.
// - Timer mode I/O 001 or 01x gives channel C compare output on port 3 bit 4.
// - Port 3 bit 4 feeds channel C capture when I/O field top bit is 1.
// - Channel C output drives port 3 bit 4 regardless of direction bit.
`ifndef PPFS_REGS_SVH
`define PPFS_REGS_SVH
`define PPFS_ADDR_W 4
`define PPFS_OFF_PORT 4'h0
`define PPFS_OFF_DIR 4'h1
`define PPFS_OFF_PULL 4'h2
`define PPFS_OFF_PMODE 4'h3
`define PPFS_OFF_TMRA 4'h4
`define PPFS_OFF_TMRB 4'h5
`define PPFS_OFF_SER 4'h6
`define PPFS_OFF_TMRC 4'h7
`define PPFS_OFF_PIN 4'h8
`define PPFS_OFF_FUNC 4'h9
`define PPFS_RST_ZERO 8'h00
// Port/dir/pin bits
`define PPFS_B_P17 0
`define PPFS_B_P31 1
`define PPFS_B_P33 2
`define PPFS_B_P34 3
// Pull-up control
`define PPFS_B_PU_P1H 0
`define PPFS_B_PU_P3A 1
`define PPFS_B_PU_P3B 2
// Pin mode select
`define PPFS_B_SERIAL_SELECT_PIN_CHOICE 0
`define PPFS_B_EXT_IRQ1_PIN_CHOICE 1
`define PPFS_B_I2CSEL 2
`define PPFS_B_INT1EN 3
`define PPFS_B_INT3EN 4
// Timer A: [0] io select, [1] port output ctrl, [4:2] mode
`define PPFS_B_TA_IOSEL 0
`define PPFS_B_TA_PCTL 1
`define PPFS_TA_MODE_LO 2
`define PPFS_TA_MODE_HI 4
`define PPFS_TA_PULSE 3'h1
// Timer B: [0] pin choice, [1] output ctrl, [3:2] mode
`define PPFS_B_TB_SEL 0
`define PPFS_B_TB_OCTL 1
`define PPFS_TB_MODE_LO 2
`define PPFS_TB_MODE_HI 3
`define PPFS_TB_WAVE 2'h1
`define PPFS_TB_TIMER 2'h0
// Serial: [0] open drain, [1] bidir, [2] chip sel od, [4:3] css,
// [5] ssi out ctl, [6] ssi in ctl, [7] i2c enable
`define PPFS_B_SERIAL_OUT_OPEN_DRAIN 0
`define PPFS_B_BIDIR 1
`define PPFS_B_CSOD 2
`define PPFS_CSS_LO 3
`define PPFS_CSS_HI 4
`define PPFS_B_SSI_OUT 5
`define PPFS_B_SSI_IN 6
`define PPFS_B_I2C_EN 7
`define PPFS_CSS_OUT 2'h2
`define PPFS_CSS_IN 2'h3
// Timer C: [0] pin choice, [1] out disable, [2] pwm2, [3] pwm, [6:4] io,
// [10:8] clock source
`define PPFS_B_TC_SEL 0
`define PPFS_B_TC_DIS 1
`define PPFS_B_TC_PWM2 2
`define PPFS_B_TC_CHANNEL_C_PWM_ENABLE 3
`define PPFS_TC_IO_LO 4
`define PPFS_TC_IO_HI 6
`define PPFS_TC_CK_LO 8
`define PPFS_TC_CK_HI 10
`define PPFS_TC_IO_CMP1 3'h1
`define PPFS_TC_CK_EXT 3'h5
`endif

/* File: shared/ppfs_pkg.sv */
package ppfs_pkg;
  typedef enum logic [1:0] {
    PPFS_FN_GPIO_IN,
    PPFS_FN_GPIO_OUT,
    PPFS_FN_PERIPH_OUT,
    PPFS_FN_PERIPH_IN
  } ppfs_func_t;
  typedef enum {
    PPFS_BUS_IDLE,
    PPFS_BUS_ACK
  } ppfs_bus_st_t;
endpackage

/* File: rtl/ppfs_pin_cell.sv */
`timescale 1ns/1ns
`include "ppfs_regs.svh"
module ppfs_pin_cell
  import ppfs_pkg::*;
(
  // Clocking
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  // Selection
  input wire logic i_dir,
  input wire logic i_port_val,
  input wire logic i_periph_drv,
  input wire logic i_periph_val,
  input wire logic i_periph_in,
  input wire logic i_open_drain,
  input wire logic i_pu_en,
  // Pad
  input wire logic i_pad,
  output logic o_pad_out,
  output logic o_pad_oe,
  output logic o_pull_up,
  output logic o_in_val,
  output ppfs_pkg::ppfs_func_t o_func
);
  import ppfs_pkg::*;
  logic drive;
  logic val;
  logic out_r;
  logic oe_r;
  logic pu_r;
  logic in_r;
  ppfs_func_t func_r;

  // Peripheral wins over the direction bit
  assign drive = i_periph_drv | i_dir;
  assign val = i_periph_drv ? i_periph_val : i_port_val;

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      out_r <= 1'b0;
      oe_r <= 1'b0;
      pu_r <= 1'b0;
      in_r <= 1'b0;
      func_r <= PPFS_FN_GPIO_IN;
    end else if (i_ce) begin
      // Open drain only pulls low; high releases the pin
      out_r <= val;
      oe_r <= drive & ~(i_open_drain & val);
      pu_r <= ~drive & i_pu_en;
      in_r <= i_pad;
      if (i_periph_drv) begin
        func_r <= PPFS_FN_PERIPH_OUT;
      end else if (i_periph_in) begin
        func_r <= PPFS_FN_PERIPH_IN;
      end else if (i_dir) begin
        func_r <= PPFS_FN_GPIO_OUT;
      end else begin
        func_r <= PPFS_FN_GPIO_IN;
      end
    end
  end

  assign o_pad_out = out_r;
  assign o_pad_oe = oe_r;
  assign o_pull_up = pu_r;
  assign o_in_val = in_r;
  assign o_func = func_r;
endmodule

/* File: rtl/ppfs_top.sv */
// Added by the designer: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "ppfs_regs.svh"
module ppfs_top
  import ppfs_pkg::*;
(
  // Clocking
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  // Avalon-MM slave
  input wire logic [`PPFS_ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Peripheral outputs toward pins
  input wire logic i_timer_a_out,
  input wire logic i_timer_b_out,
  input wire logic i_ssi_out,
  input wire logic i_scs_out,
  input wire logic i_i2c_sda_out,
  input wire logic i_tc_chan_c_out,
  // Pads: 0=P1_7 1=P3_1 2=P3_3 3=P3_4
  input wire logic [3:0] i_pad_in,
  output logic [3:0] o_pad_out,
  output logic [3:0] o_pad_oe,
  output logic [3:0] o_pad_pull_up,
  // Peripheral inputs from pins
  output logic o_ext_irq1,
  output logic o_ext_irq3,
  output logic o_timer_a_in,
  output logic o_ssi_in,
  output logic o_scs_in,
  output logic o_i2c_sda_in,
  output logic o_tc_ext_clock,
  output logic o_tc_capture_c
);
  import ppfs_pkg::*;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] port_r;
  logic [7:0] dir_r;
  logic [7:0] pullup_control_reg_r;
  logic [7:0] pin_mode_select_reg_r;
  logic [7:0] timer_a_io_control_reg_r;
  logic [7:0] timer_b_io_control_reg_r;
  logic [7:0] sync_serial_mode_reg2_r;
  logic [15:0] timer_c_mode_reg_r;
  ppfs_bus_st_t bus_st_r;
  logic [31:0] rdata_r;
  logic wr_go;
  logic rd_go;

  // One wait cycle; requests taken in idle, answered next edge
  assign wr_go = i_ce & i_avs_write & (bus_st_r == PPFS_BUS_IDLE);
  assign rd_go = i_ce & i_avs_read & (bus_st_r == PPFS_BUS_IDLE);
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & (bus_st_r == PPFS_BUS_IDLE);

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      bus_st_r <= PPFS_BUS_IDLE;
    end else if (i_ce) begin
      case (bus_st_r)
        PPFS_BUS_IDLE: begin
          if (i_avs_read | i_avs_write) begin
            bus_st_r <= PPFS_BUS_ACK;
          end
        end
        PPFS_BUS_ACK: bus_st_r <= PPFS_BUS_IDLE;
        default: bus_st_r <= PPFS_BUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      port_r <= `PPFS_RST_ZERO;
      dir_r <= `PPFS_RST_ZERO;
      pullup_control_reg_r <= `PPFS_RST_ZERO;
      pin_mode_select_reg_r <= `PPFS_RST_ZERO;
      timer_a_io_control_reg_r <= `PPFS_RST_ZERO;
      timer_b_io_control_reg_r <= `PPFS_RST_ZERO;
      sync_serial_mode_reg2_r <= `PPFS_RST_ZERO;
      timer_c_mode_reg_r <= {`PPFS_RST_ZERO, `PPFS_RST_ZERO};
    end else if (wr_go && i_avs_byteenable[0]) begin
      case (i_avs_address)
        `PPFS_OFF_PORT: port_r <= i_avs_writedata[7:0];
        `PPFS_OFF_DIR: dir_r <= i_avs_writedata[7:0];
        `PPFS_OFF_PULL: pullup_control_reg_r <= i_avs_writedata[7:0];
        `PPFS_OFF_PMODE: pin_mode_select_reg_r <= i_avs_writedata[7:0];
        `PPFS_OFF_TMRA: timer_a_io_control_reg_r <= i_avs_writedata[7:0];
        `PPFS_OFF_TMRB: timer_b_io_control_reg_r <= i_avs_writedata[7:0];
        `PPFS_OFF_SER: sync_serial_mode_reg2_r <= i_avs_writedata[7:0];
        `PPFS_OFF_TMRC: begin
          timer_c_mode_reg_r[7:0] <= i_avs_writedata[7:0];
          if (i_avs_byteenable[1]) begin
            timer_c_mode_reg_r[15:8] <= i_avs_writedata[15:8];
          end
        end
        default: begin
        end
      endcase
    end else if (wr_go && i_avs_byteenable[1] && i_avs_address == `PPFS_OFF_TMRC) begin
      timer_c_mode_reg_r[15:8] <= i_avs_writedata[15:8];
    end
  end

  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  logic serial_select_pin_choice;
  logic ext_irq1_pin_choice;
  logic i2csel;
  logic int1_en;
  logic int3_en;
  logic ta_iosel;
  logic ta_pctl;
  logic [2:0] ta_mode;
  logic tb_sel;
  logic tb_octl;
  logic [1:0] tb_mode;
  logic [1:0] css;
  logic ssi_out_ctl;
  logic ssi_in_ctl;
  logic i2c_en;
  logic tc_sel;
  logic tc_dis;
  logic tc_pwm2;
  logic tc_channel_c_pwm_enable;
  logic [2:0] tc_io;
  logic [2:0] tc_ck;

  assign serial_select_pin_choice = pin_mode_select_reg_r[`PPFS_B_SERIAL_SELECT_PIN_CHOICE];
  assign ext_irq1_pin_choice = pin_mode_select_reg_r[`PPFS_B_EXT_IRQ1_PIN_CHOICE];
  assign i2csel = pin_mode_select_reg_r[`PPFS_B_I2CSEL];
  assign int1_en = pin_mode_select_reg_r[`PPFS_B_INT1EN];
  assign int3_en = pin_mode_select_reg_r[`PPFS_B_INT3EN];
  assign ta_iosel = timer_a_io_control_reg_r[`PPFS_B_TA_IOSEL];
  assign ta_pctl = timer_a_io_control_reg_r[`PPFS_B_TA_PCTL];
  assign ta_mode = timer_a_io_control_reg_r[`PPFS_TA_MODE_HI:`PPFS_TA_MODE_LO];
  assign tb_sel = timer_b_io_control_reg_r[`PPFS_B_TB_SEL];
  assign tb_octl = timer_b_io_control_reg_r[`PPFS_B_TB_OCTL];
  assign tb_mode = timer_b_io_control_reg_r[`PPFS_TB_MODE_HI:`PPFS_TB_MODE_LO];
  assign css = sync_serial_mode_reg2_r[`PPFS_CSS_HI:`PPFS_CSS_LO];
  assign ssi_out_ctl = sync_serial_mode_reg2_r[`PPFS_B_SSI_OUT];
  assign ssi_in_ctl = sync_serial_mode_reg2_r[`PPFS_B_SSI_IN];
  assign i2c_en = sync_serial_mode_reg2_r[`PPFS_B_I2C_EN];
  assign tc_sel = timer_c_mode_reg_r[`PPFS_B_TC_SEL];
  assign tc_dis = timer_c_mode_reg_r[`PPFS_B_TC_DIS];
  assign tc_pwm2 = timer_c_mode_reg_r[`PPFS_B_TC_PWM2];
  assign tc_channel_c_pwm_enable = timer_c_mode_reg_r[`PPFS_B_TC_CHANNEL_C_PWM_ENABLE];
  assign tc_io = timer_c_mode_reg_r[`PPFS_TC_IO_HI:`PPFS_TC_IO_LO];
  assign tc_ck = timer_c_mode_reg_r[`PPFS_TC_CK_HI:`PPFS_TC_CK_LO];

  // ----------------------------------------
  // Function claims
  // ----------------------------------------
  logic ta_pulse;
  logic ta_in_use;
  logic tb_drive;
  logic ssi_here;
  logic ssi_drive;
  logic ssi_listen;
  logic tc_base;
  logic tc_pwm_out;
  logic tc_cmp_out;
  logic tc_drive;
  logic tc_cap;
  logic scs_drive;
  logic sda_use;
  logic [3:0] periph_drv;
  logic [3:0] periph_val;
  logic [3:0] periph_in;
  logic [3:0] open_drain;
  logic [3:0] pu_en;
  logic [3:0] pin_in;
  ppfs_func_t func [4];

  // Pulse output mode: timer A owns the pin; port control must be 0
  assign ta_pulse = ~ta_iosel & ~ta_pctl & (ta_mode == `PPFS_TA_PULSE);
  assign ta_in_use = ~ta_iosel & ~ta_pctl & (ta_mode != `PPFS_TA_PULSE)
    & (ta_mode != 3'h0);
  // timer B pin claim; control 1 falls back to the port
  assign tb_drive = ~tb_sel & ~tb_octl & (tb_mode != `PPFS_TB_TIMER);
  assign ssi_here = ~serial_select_pin_choice & ~i2csel;
  assign ssi_drive = ssi_here & ssi_out_ctl;
  assign ssi_listen = ssi_here & ssi_in_ctl;
  assign tc_base = tc_sel & ~tc_dis & tc_pwm2;
  assign tc_pwm_out = tc_base & tc_channel_c_pwm_enable;
  // compare output for io 001 or 01x
  assign tc_cmp_out = tc_base & ~tc_channel_c_pwm_enable & ~tc_io[2] & (tc_io[1] | tc_io == `PPFS_TC_IO_CMP1);
  assign tc_drive = tc_pwm_out | tc_cmp_out;
  assign scs_drive = ~i2csel & (css == `PPFS_CSS_OUT) & ~tc_drive;
  assign sda_use = i2csel & i2c_en;

  // timer B beats the direction bit; as does channel C
  assign periph_drv = {tc_drive | scs_drive | sda_use, ssi_drive, tb_drive, ta_pulse};
  assign periph_val = {
    tc_drive ? i_tc_chan_c_out : (scs_drive ? i_scs_out : i_i2c_sda_out),
    i_ssi_out, i_timer_b_out, i_timer_a_out};
  assign periph_in = {
    (tc_sel & tc_pwm2 & ~tc_channel_c_pwm_enable & tc_io[2]) | (css == `PPFS_CSS_IN) | sda_use,
    ssi_listen | int3_en | (tc_ck == `PPFS_TC_CK_EXT),
    1'b0,
    ta_in_use | (~ext_irq1_pin_choice & int1_en)};
  // serial output open drain; chip select open drain
  assign open_drain = {
    (scs_drive & sync_serial_mode_reg2_r[`PPFS_B_CSOD]) | sda_use,
    sync_serial_mode_reg2_r[`PPFS_B_SERIAL_OUT_OPEN_DRAIN] & ~sync_serial_mode_reg2_r[`PPFS_B_BIDIR],
    1'b0, 1'b0};
  assign pu_en = {
    pullup_control_reg_r[`PPFS_B_PU_P3B],
    pullup_control_reg_r[`PPFS_B_PU_P3A],
    pullup_control_reg_r[`PPFS_B_PU_P3A],
    pullup_control_reg_r[`PPFS_B_PU_P1H]};

  // general port fallback inside each cell
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_pin
      ppfs_pin_cell u_cell (
        .i_sys_clk(i_sys_clk),
        .i_srst(i_srst),
        .i_ce(i_ce),
        .i_dir(dir_r[g]),
        .i_port_val(port_r[g]),
        .i_periph_drv(periph_drv[g]),
        .i_periph_val(periph_val[g]),
        .i_periph_in(periph_in[g]),
        .i_open_drain(open_drain[g]),
        .i_pu_en(pu_en[g]),
        .i_pad(i_pad_in[g]),
        .o_pad_out(o_pad_out[g]),
        .o_pad_oe(o_pad_oe[g]),
        .o_pull_up(o_pad_pull_up[g]),
        .o_in_val(pin_in[g]),
        .o_func(func[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // Inputs to peripherals
  // ----------------------------------------
  // interrupt 1 from port 1 bit 7
  assign o_ext_irq1 = ~ext_irq1_pin_choice & int1_en & pin_in[`PPFS_B_P17];
  assign o_timer_a_in = ta_in_use & pin_in[`PPFS_B_P17];
  assign o_ext_irq3 = int3_en & pin_in[`PPFS_B_P33];
  assign o_ssi_in = ssi_listen & pin_in[`PPFS_B_P33];
  assign o_tc_ext_clock = ~dir_r[`PPFS_B_P33] & ~ssi_drive & ~ssi_listen
    & (tc_ck == `PPFS_TC_CK_EXT) & pin_in[`PPFS_B_P33];
  assign o_scs_in = ~i2csel & (css == `PPFS_CSS_IN) & pin_in[`PPFS_B_P34];
  assign o_i2c_sda_in = sda_use & pin_in[`PPFS_B_P34];
  assign o_tc_capture_c = tc_sel & tc_pwm2 & ~tc_channel_c_pwm_enable & tc_io[2] & pin_in[`PPFS_B_P34];

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      rdata_r <= 32'h00000000;
    end else if (rd_go) begin
      case (i_avs_address)
        `PPFS_OFF_PORT: rdata_r <= {24'h000000, port_r};
        `PPFS_OFF_DIR: rdata_r <= {24'h000000, dir_r};
        `PPFS_OFF_PULL: rdata_r <= {24'h000000, pullup_control_reg_r};
        `PPFS_OFF_PMODE: rdata_r <= {24'h000000, pin_mode_select_reg_r};
        `PPFS_OFF_TMRA: rdata_r <= {24'h000000, timer_a_io_control_reg_r};
        `PPFS_OFF_TMRB: rdata_r <= {24'h000000, timer_b_io_control_reg_r};
        `PPFS_OFF_SER: rdata_r <= {24'h000000, sync_serial_mode_reg2_r};
        `PPFS_OFF_TMRC: rdata_r <= {16'h0000, timer_c_mode_reg_r};
        `PPFS_OFF_PIN: rdata_r <= {28'h0000000, pin_in};
        `PPFS_OFF_FUNC: rdata_r <= {24'h000000, func[3], func[2], func[1], func[0]};
        default: rdata_r <= 32'h00000000;
      endcase
    end
  end
  assign o_avs_readdata = rdata_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_pu_p17;
    @(posedge i_sys_clk) disable iff (i_srst)
      i_ce && !dir_r[0] && !ta_pulse |=> o_pad_pull_up[0] == $past(pu_en[0]);
  endproperty
  a_pu_p17: assert property (p_pu_p17) else $error("p1.7 pullup wrong");
  property p_pu_p3a;
    @(posedge i_sys_clk) disable iff (i_srst)
      i_ce && !pullup_control_reg_r[1] |=> !o_pad_pull_up[1] && !o_pad_pull_up[2];
  endproperty
  a_pu_p3a: assert property (p_pu_p3a) else $error("shared pullup on");
  property p_pu_p34;
    @(posedge i_sys_clk) disable iff (i_srst)
      i_ce && !pullup_control_reg_r[2] |=> !o_pad_pull_up[3];
  endproperty
  a_pu_p34: assert property (p_pu_p34) else $error("p3.4 pullup on");
  property p_irq1;
    @(posedge i_sys_clk) disable iff (i_srst) ext_irq1_pin_choice |-> !o_ext_irq1;
  endproperty
  a_irq1: assert property (p_irq1) else $error("irq1 from wrong pin");
  property p_tb_drv;
    @(posedge i_sys_clk) disable iff (i_srst)
      i_ce && tb_drive |=> o_pad_oe[1] && o_pad_out[1] == $past(i_timer_b_out);
  endproperty
  a_tb_drv: assert property (p_tb_drv) else $error("timer B not driven");
  property p_tc_drv;
    @(posedge i_sys_clk) disable iff (i_srst)
      i_ce && tc_drive |=> o_pad_out[3] == $past(i_tc_chan_c_out);
  endproperty
  a_tc_drv: assert property (p_tc_drv) else $error("chan C not driven");
  property p_od33;
    @(posedge i_sys_clk) disable iff (i_srst)
      i_ce && ssi_drive && open_drain[2] && i_ssi_out |=> !o_pad_oe[2];
  endproperty
  a_od33: assert property (p_od33) else $error("p3.3 drives high");
  property p_gpio;
    @(posedge i_sys_clk) disable iff (i_srst)
      i_ce && !periph_drv[1] |=> o_pad_oe[1] == $past(dir_r[1]);
  endproperty
  a_gpio: assert property (p_gpio) else $error("gpio dir ignored");
endmodule

/* File: dv/ppfs_pad_model.sv */
`timescale 1ns/1ns
module ppfs_pad_model (
  // Clock
  input wire logic i_sys_clk,
  // Device side of the pads
  input wire logic [3:0] i_dut_out,
  input wire logic [3:0] i_dut_oe,
  input wire logic [3:0] i_pull_up,
  // Board drivers
  input wire logic [3:0] i_ext_en,
  input wire logic [3:0] i_ext_val,
  // Resolved wire level
  output logic [3:0] o_level
);
  // ----------------------------------------
  // Floating pins
  // ----------------------------------------
  // Toggles so a released pin never reads as a stable level
  logic [3:0] float_r = 4'h5;

  always @(posedge i_sys_clk) begin
    float_r <= ~float_r;
  end

  // ----------------------------------------
  // Wire resolution
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (i_dut_oe[i]) begin
        o_level[i] = i_dut_out[i];
      end else if (i_ext_en[i]) begin
        o_level[i] = i_ext_val[i];
      end else if (i_pull_up[i]) begin
        o_level[i] = 1'b1;
      end else begin
        o_level[i] = float_r[i];
      end
    end
  end
endmodule

/* File: dv/ppfs_top_tb.sv */
`timescale 1ns/1ns
module ppfs_top_tb;
  import ppfs_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'hF;
  logic [31:0] rdata;
  logic wait_req;
  logic ta_o = 1'b0, tb_o = 1'b0, ssi_o = 1'b0, scs_o = 1'b0, sda_o = 1'b0, tcc_o = 1'b0;
  logic [3:0] lvl, pad_out, pad_oe, pad_pu;
  logic [3:0] ext_en = 4'h0;
  logic [3:0] ext_val = 4'h0;
  logic irq1, irq3, ta_in, ssi_in, scs_in, sda_in, tc_ck, tc_cap;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;

  ppfs_top dut (.i_sys_clk(clk), .i_srst(srst), .i_ce(1'b1), .i_avs_address(addr),
    .i_avs_read(rd_en), .i_avs_write(wr_en), .i_avs_writedata(wdata),
    .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req),
    .i_timer_a_out(ta_o), .i_timer_b_out(tb_o), .i_ssi_out(ssi_o), .i_scs_out(scs_o),
    .i_i2c_sda_out(sda_o), .i_tc_chan_c_out(tcc_o), .i_pad_in(lvl), .o_pad_out(pad_out),
    .o_pad_oe(pad_oe), .o_pad_pull_up(pad_pu), .o_ext_irq1(irq1), .o_ext_irq3(irq3),
    .o_timer_a_in(ta_in), .o_ssi_in(ssi_in), .o_scs_in(scs_in), .o_i2c_sda_in(sda_in),
    .o_tc_ext_clock(tc_ck), .o_tc_capture_c(tc_cap));

  ppfs_pad_model board (.i_sys_clk(clk), .i_dut_out(pad_out), .i_dut_oe(pad_oe),
    .i_pull_up(pad_pu), .i_ext_en(ext_en), .i_ext_val(ext_val), .o_level(lvl));

  initial begin
    forever #4 clk = ~clk;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic finish_test();
    $display("Checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Request held until a rising edge sees waitrequest low; only the timeout ends a wait
  task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d,
                     input logic [3:0] b, output logic [31:0] q);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    be <= b;
    wr_en <= w;
    rd_en <= ~w;
    do begin
      @(posedge clk);
    end while (wait_req !== 1'b0);
    q = rdata;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, 4'hF, q);
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, 4'hF, q);
    chk(q, exp);
  endtask

  // Pad outputs are registered one cycle after their cause
  task automatic settle();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic pin(input int i, input logic oe, input logic v);
    chk(pad_oe[i], oe);
    if (oe) chk(pad_out[i], v);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] tc_cfg [9];
    logic [7:0] c;
    logic [31:0] q;
    logic dr, od, cap;
    tc_cfg = '{8'h0D, 8'h15, 8'h25, 8'h35, 8'h45, 8'h47, 8'h0F, 8'h0C, 8'h05};
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 8; i++) rd_chk(4'(i), 32'h0);
    wr(4'hA, 32'hFF);
    rd_chk(4'hA, 32'h0);
    settle();
    chk(pad_oe, 4'h0);
    chk(pad_pu, 4'h0);
    @(posedge clk);
    ext_en <= 4'hF;
    ext_val <= 4'hA;
    settle();
    rd_chk(4'h8, 32'hA);
    rd_chk(4'h9, 32'h0);
    @(posedge clk);
    ext_en <= 4'h0;
    wr(4'h1, 32'hF);
    wr(4'h0, 32'h5);
    settle();
    chk({pad_oe, pad_out}, 8'hF5);
    rd_chk(4'h9, 32'h55);
    wr(4'h0, 32'h0);
    for (int k = 0; k < 8; k++) begin
      wr(4'h1, 32'h0);
      wr(4'h2, 32'(k));
      settle();
      chk(pad_pu, {k[2], k[1], k[1], k[0]});
      wr(4'h1, 32'hF);
      settle();
      chk(pad_pu, 4'h0);
    end
    wr(4'h1, 32'h0);
    wr(4'h2, 32'h0);
    for (int m = 0; m < 8; m++) begin
      wr(4'h3, (32'(m[1]) << 3) | (32'(m[1]) << 4) | (32'(m[0]) << 1));
      ext_en <= 4'h5;
      ext_val <= {1'b0, m[2], 1'b0, m[2]};
      settle();
      chk(irq1, m[2] & m[1] & ~m[0]);
      chk(irq3, m[2] & m[1]);
    end
    wr(4'h3, 32'h0);
    wr(4'h4, 32'h04);
    for (int v = 0; v < 2; v++) begin
      @(posedge clk);
      ta_o <= v[0];
      settle();
      pin(0, 1'b1, v[0]);
    end
    wr(4'h4, 32'h0);
    for (int m = 0; m < 8; m++) begin
      wr(4'h5, 32'(m[1:0]) << 2);
      tb_o <= m[2];
      settle();
      pin(1, m[1:0] != 2'b00, m[2]);
    end
    wr(4'h1, 32'h2);
    wr(4'h5, 32'h06);
    settle();
    pin(1, 1'b1, 1'b0);
    wr(4'h5, 32'h05);
    settle();
    pin(1, 1'b1, 1'b0);
    wr(4'h1, 32'h0);
    wr(4'h5, 32'h0);
    for (int m = 0; m < 16; m++) begin
      wr(4'h3, 32'(m[0]));
      wr(4'h6, 32'h20 | 32'(m[1]) | (32'(m[2]) << 1));
      ssi_o <= m[3];
      dr = ~m[0];
      od = m[1] & ~m[2];
      settle();
      pin(2, dr & ~(od & m[3]), m[3]);
    end
    wr(4'h6, 32'h40);
    for (int m = 0; m < 2; m++) begin
      wr(4'h3, 32'(m));
      ext_en <= 4'h4;
      ext_val <= 4'h4;
      settle();
      chk(ssi_in, !m[0]);
    end
    wr(4'h6, 32'h0);
    wr(4'h3, 32'h0);
    bus(4'h7, 1'b1, 32'h500, 4'h1, q);
    rd_chk(4'h7, 32'h0);
    bus(4'h7, 1'b1, 32'h500, 4'h3, q);
    rd_chk(4'h7, 32'h500);
    for (int v = 0; v < 2; v++) begin
      @(posedge clk);
      ext_val <= 4'(v) << 2;
      settle();
      chk(tc_ck, v[0]);
    end
    // Pin driven high as an output, so only the direction gate can hold the clock low
    wr(4'h0, 32'h4);
    wr(4'h1, 32'h4);
    settle();
    chk(tc_ck, 1'b0);
    wr(4'h1, 32'h0);
    wr(4'h0, 32'h0);
    for (int m = 0; m < 4; m++) begin
      wr(4'h6, 32'h10 | (32'(m[1]) << 2));
      scs_o <= m[0];
      settle();
      pin(3, ~(m[1] & m[0]), m[0]);
    end
    wr(4'h6, 32'h0);
    for (int i = 0; i < 9; i++) begin
      c = tc_cfg[i];
      dr = c[0] & ~c[1] & c[2] & (c[3] | c[6:4] == 3'h1 | c[6:5] == 2'h1);
      cap = c[0] & c[2] & ~c[3] & c[6];
      wr(4'h7, 32'(c));
      for (int v = 0; v < 2; v++) begin
        @(posedge clk);
        tcc_o <= v[0];
        ext_en <= dr ? 4'h0 : 4'h8;
        ext_val <= 4'(v) << 3;
        settle();
        pin(3, dr, v[0]);
        chk(tc_cap, cap & v[0]);
      end
    end
    wr(4'h7, 32'h0);
    // Bus data line: low is driven, high is released to the board
    wr(4'h3, 32'h04);
    wr(4'h6, 32'h80);
    for (int v = 0; v < 2; v++) begin
      @(posedge clk);
      sda_o <= v[0];
      ext_en <= 4'h9;
      ext_val <= 4'h9;
      settle();
      pin(3, !v[0], 1'b0);
      chk(sda_in, v[0]);
    end
    wr(4'h3, 32'h0);
    wr(4'h6, 32'h18);
    wr(4'h4, 32'h08);
    for (int v = 0; v < 2; v++) begin
      @(posedge clk);
      ext_val <= {v[0], 2'b00, v[0]};
      settle();
      chk(scs_in, v[0]);
      chk(ta_in, v[0]);
    end
    finish_test();
  end
endmodule
